// File: src/tsr_pkg.sv
// Package for the time-slot routing engine: constants, entry layout and types.
// Behaviour
// - Two static channels get 64 entries each.
// - Two dynamic channels get 32 plus 32 shadow.
// - Swap request exchanges partitions at next sync.
// - Request bit clears once exchange completes.
// - One dynamic channel's partitions start at 0, 64, 128, 192.
// - Loop bit of receive entries loops back the time slot.
// - Pin swap honoured only from receive entries.
// - Swapped entry exchanges transmit and receive pins.
// - Strobes follow receive or transmit clock.
// - Strobe bits give strobe level per group.
// - Consecutive selected entries keep strobe gapless.
// - Strobes drop after last entry finishes.
// - Strobes reach pins only when dedicated.
// - Strobe shared by sources is their OR.
// - Channel code zero routes nowhere, pin floats.
// - Codes one to four pick serial controllers, five and six management controllers.
// - Code seven routes nowhere, grant in telecom.
// - Entry covers count plus one units.
// - Granularity bit picks bits or bytes.
// - Last entry waits for sync, then restarts.
package tsr_pkg;
   localparam int RAM_WORDS   = 256;
   localparam int ADDR_W      = 8;
   localparam int NUM_STROBES = 4;
   localparam int NUM_DEST    = 6;

   localparam logic [1:0] MODE_ONE_STATIC  = 2'h0;
   localparam logic [1:0] MODE_ONE_DYNAMIC = 2'h1;
   localparam logic [1:0] MODE_TWO_STATIC  = 2'h2;
   localparam logic [1:0] MODE_TWO_DYNAMIC = 2'h3;

   // Partition bases, word addresses (rx section 0..127, tx section 128..255).
   localparam logic [7:0] BASE_RX_A = 8'h00;
   localparam logic [7:0] BASE_RX_B = 8'h40;
   localparam logic [7:0] BASE_TX_A = 8'h80;
   localparam logic [7:0] BASE_TX_B = 8'hc0;
   localparam logic [7:0] SIZE_64   = 8'h40;
   localparam logic [7:0] SIZE_32   = 8'h20;
   localparam logic [7:0] SIZE_16   = 8'h10;

   localparam int BIT_LOOP = 15;
   localparam int BIT_SWAP = 14;
   localparam int BIT_STB_HI = 13;
   localparam int BIT_STB_LO = 10;
   localparam int BIT_CH_HI = 8;
   localparam int BIT_CH_LO = 6;
   localparam int BIT_CNT_HI = 5;
   localparam int BIT_CNT_LO = 2;
   localparam int BIT_BYTE = 1;
   localparam int BIT_LAST = 0;

   localparam logic [2:0] CH_NONE  = 3'h0;
   localparam logic [2:0] CH_GRANT = 3'h7;
   localparam logic [3:0] BITS_PER_BYTE_M1 = 4'h7;
   localparam logic [3:0] RESET_CNT = 4'h0;

   typedef struct packed {
      logic       loopSlot;
      logic       swapTxRxPins;
      logic [3:0] strobeSelectBits;
      logic       reserved;
      logic [2:0] channelRouteSelect;
      logic [3:0] groupCount;
      logic       byteGranularity;
      logic       lastRouteEntry;
   } tsr_entry_s;

   typedef struct packed {
      logic       active;
      logic       loopSlot;
      logic       swapTxRxPins;
      logic [3:0] strobes;
      logic [2:0] channelRouteSelect;
      logic [5:0] destOneHot;
      logic       dChanGrant;
   } tsr_slot_s;

   typedef enum logic [1:0] {TSR_IDLE, TSR_RUN, TSR_FETCH} tsr_state_e;

   function automatic tsr_entry_s tsr_decode(input logic [15:0] w);
      tsr_decode = tsr_entry_s'(w);
   endfunction : tsr_decode
endpackage : tsr_pkg

// File: src/tsr_sync.sv
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ps
`default_nettype none
module tsr_sync #(parameter int WIDTH = 1) (
   input  wire logic             clk_sys,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1_ff;
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         stage1_ff <= '0;
         syncOut   <= '0;
      end else begin
         stage1_ff <= asyncIn;
         syncOut   <= stage1_ff;
      end
   end
endmodule : tsr_sync
`default_nettype wire

// File: src/tsr_sequencer.sv
// One route sequencer: walks a partition of route memory on one TDM clock.
`timescale 1ns/1ps
`default_nettype none
module tsr_sequencer (
   input  wire logic                    clk_sys,
   input  wire logic                    reset_n,
   input  wire logic                    enable,
   input  wire logic                    clkEdge,
   input  wire logic                    syncSeen,
   input  wire logic [tsr_pkg::ADDR_W-1:0] baseAddr,
   output logic      [tsr_pkg::ADDR_W-1:0] rdAddr,
   input  wire logic [15:0]             rdData,
   output tsr_pkg::tsr_slot_s           slot,
   output logic                         frameStart
);
   import tsr_pkg::*;
   tsr_state_e state_ff;
   logic [ADDR_W-1:0] ptr_ff;
   logic [3:0]        unitCnt_ff;
   logic [2:0]        bitCnt_ff;
   tsr_entry_s        ent;
   logic              entDone;
   logic              unitDone;

   assign rdAddr     = ptr_ff;
   assign ent        = tsr_decode(rdData);
   assign frameStart = clkEdge && syncSeen && enable;
   assign unitDone   = !ent.byteGranularity || (bitCnt_ff == BITS_PER_BYTE_M1[2:0]);
   assign entDone    = unitDone && (unitCnt_ff == ent.groupCount);

   always_ff @(posedge clk_sys) begin
      if (!reset_n || !enable) begin
         state_ff   <= TSR_IDLE;
         ptr_ff     <= '0;
         unitCnt_ff <= RESET_CNT;
         bitCnt_ff  <= '0;
      end else if (frameStart) begin
         state_ff   <= TSR_RUN;
         ptr_ff     <= baseAddr;
         unitCnt_ff <= RESET_CNT;
         bitCnt_ff  <= '0;
      end else if (clkEdge && state_ff == TSR_RUN) begin
         bitCnt_ff <= bitCnt_ff + 3'h1;
         if (unitDone) begin
            bitCnt_ff  <= '0;
            unitCnt_ff <= unitCnt_ff + 4'h1;
         end
         if (entDone) begin
            unitCnt_ff <= RESET_CNT;
            if (ent.lastRouteEntry) begin
               state_ff <= TSR_IDLE;
            end else begin
               ptr_ff <= ptr_ff + 8'h01;
            end
         end
      end
   end

   always_comb begin
      slot = '0;
      // The sync edge only loads the partition base; units are taken from the next edge on.
      if (state_ff == TSR_RUN) begin
         slot.active             = 1'b1;
         slot.loopSlot           = ent.loopSlot;
         slot.swapTxRxPins       = ent.swapTxRxPins;
         slot.strobes            = ent.strobeSelectBits;
         slot.channelRouteSelect = ent.channelRouteSelect;
         for (int i = 0; i < NUM_DEST; i++) begin
            slot.destOneHot[i] = (ent.channelRouteSelect == 3'(i + 1));
         end
         slot.dChanGrant = (ent.channelRouteSelect == CH_GRANT);
      end
   end
endmodule : tsr_sequencer
`default_nettype wire

// File: src/tsr_slot_route.sv
// Time-slot routing engine top: route memory, four sequencers, pins and strobes.
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tsr_slot_route (
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // AHB-Lite slave.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // TDM pins.
   input  wire logic        rx_clock_chan_a,
   input  wire logic        rx_clock_chan_b,
   input  wire logic        tx_clock_chan_a,
   input  wire logic        tx_clock_chan_b,
   input  wire logic        rx_sync_chan_a,
   input  wire logic        rx_sync_chan_b,
   input  wire logic        tx_sync_chan_a,
   input  wire logic        tx_sync_chan_b,
   input  wire logic        tdmRxDataPinIn,
   output logic             tdmRxDataPinOut,
   output logic             tdmRxDataPinOe,
   input  wire logic        tdmTxDataPinIn,
   output logic             tdmTxDataPinOut,
   output logic             tdmTxDataPinOe,
   output logic             strobe_a1_pin,
   output logic             strobe_a2_pin,
   output logic             strobe_b1_pin,
   output logic             strobe_b2_pin,
   // Internal controllers: serial_ctrl_1..4, mgmt_ctrl_1..2 in index order 0..5.
   input  wire logic [5:0]  ctrlTxData,
   output logic      [5:0]  ctrlRxData,
   output logic      [5:0]  ctrlRxValid,
   output logic      [5:0]  ctrlTxTake,
   output logic             dChanGrant
);
   import tsr_pkg::*;
   localparam logic [11:0] OFS_CTRL = 12'h400;
   localparam logic [11:0] OFS_STAT = 12'h404;

   // Route memory, word address = byte address / 4.
   logic [15:0] ram [RAM_WORDS];
   logic [1:0]  ramDivisionMode_ff;
   logic [3:0]  strobeSrcTx_ff;     // 1: strobe owned by transmit sets
   logic [3:0]  strobeDedicated_ff;
   logic        telecomControlMode_ff;
   logic [1:0]  chanEnable_ff;
   logic [1:0]  shadowSwapRequest_ff; // bit0 chan A, bit1 chan B
   logic [1:0]  shadowActive_ff;

   // AHB data-phase capture.
   logic        dpValid_ff;
   logic        dpWrite_ff;
   logic [11:0] dpAddr_ff;
   logic        acc;
   assign acc       = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         dpValid_ff <= 1'b0;
         dpWrite_ff <= 1'b0;
         dpAddr_ff  <= '0;
      end else begin
         dpValid_ff <= acc;
         dpWrite_ff <= hwrite;
         dpAddr_ff  <= haddr[11:0];
      end
   end

   logic dpRam;
   logic wrEn;
   assign dpRam = (dpAddr_ff[11:10] == 2'h0);
   assign wrEn  = dpValid_ff && dpWrite_ff;

   always_ff @(posedge clk_sys) begin
      if (wrEn && dpRam) begin
         ram[dpAddr_ff[9:2]] <= hwdata[15:0];
      end
   end

   // Synchronised pins: clocks, syncs, data.
   logic [9:0] pinSync;
   tsr_sync #(.WIDTH(10)) uSync (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .asyncIn ({tdmTxDataPinIn, tdmRxDataPinIn, tx_sync_chan_b, tx_sync_chan_a,
                 rx_sync_chan_b, rx_sync_chan_a, tx_clock_chan_b, tx_clock_chan_a,
                 rx_clock_chan_b, rx_clock_chan_a}),
      .syncOut (pinSync)
   );
   logic [3:0] clkPrev_ff;
   logic [3:0] rise;
   logic [3:0] fall;
   logic [3:0] syncLvl;
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         clkPrev_ff <= '0;
      end else begin
         clkPrev_ff <= pinSync[3:0];
      end
   end
   assign rise    = pinSync[3:0] & ~clkPrev_ff;
   assign fall    = ~pinSync[3:0] & clkPrev_ff;
   assign syncLvl = pinSync[7:4];

   // Sequencer index: 0 rx A, 1 rx B, 2 tx A, 3 tx B.
   logic        twoChan;
   logic        dyn;
   logic [7:0]  base [4];
   logic [7:0]  rdAddr [4];
   tsr_slot_s   slot [4];
   logic [3:0]  frameStart;
   logic [3:0]  seqEnable;
   logic [3:0]  edgeSel;
   logic [1:0]  swapDone;
   logic [1:0]  shadowNow;
   assign twoChan = ramDivisionMode_ff[1];
   assign dyn     = ramDivisionMode_ff[0];

   function automatic logic [7:0] part_base(input logic [7:0] b0, input logic shadow,
                                            input logic [1:0] mode);
      logic [7:0] sz;
      sz = SIZE_64;
      unique case (mode)
         MODE_ONE_STATIC:  sz = SIZE_64;
         MODE_ONE_DYNAMIC: sz = SIZE_64;
         MODE_TWO_STATIC:  sz = SIZE_32;
         MODE_TWO_DYNAMIC: sz = SIZE_32;
      endcase
      part_base = shadow ? b0 + sz : b0;
   endfunction : part_base

   always_comb begin
      base[0] = part_base(BASE_RX_A, shadowNow[0] & dyn, ramDivisionMode_ff);
      base[1] = part_base(BASE_RX_B, shadowNow[1] & dyn, ramDivisionMode_ff);
      base[2] = part_base(BASE_TX_A, shadowNow[0] & dyn, ramDivisionMode_ff);
      base[3] = part_base(BASE_TX_B, shadowNow[1] & dyn, ramDivisionMode_ff);
      if (ramDivisionMode_ff == MODE_ONE_DYNAMIC) begin
         base[0] = shadowNow[0] ? BASE_RX_B : BASE_RX_A;
         base[2] = shadowNow[0] ? BASE_TX_B : BASE_TX_A;
      end
   end
   assign seqEnable = {chanEnable_ff[1] & twoChan, chanEnable_ff[0],
                       chanEnable_ff[1] & twoChan, chanEnable_ff[0]};
   assign edgeSel   = {fall[3:2], rise[1:0]};

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : gSeq
         tsr_sequencer uSeq (
            .clk_sys    (clk_sys),
            .reset_n    (reset_n),
            .enable     (seqEnable[g]),
            .clkEdge    (edgeSel[g]),
            .syncSeen   (syncLvl[g]),
            .baseAddr   (base[g]),
            .rdAddr     (rdAddr[g]),
            .rdData     (ram[rdAddr[g]]),
            .slot       (slot[g]),
            .frameStart (frameStart[g])
         );
      end
   endgenerate

   // Shadow exchange on the receive sync of each channel.
   assign swapDone  = shadowSwapRequest_ff & frameStart[1:0] & {dyn, dyn};
   assign shadowNow = shadowActive_ff ^ swapDone;
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         shadowActive_ff <= 2'h0;
      end else begin
         shadowActive_ff <= shadowActive_ff ^ swapDone;
      end
   end

   // Control register writes.
   logic wrCtrl;
   assign wrCtrl = wrEn && (dpAddr_ff == OFS_CTRL);
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         ramDivisionMode_ff    <= MODE_ONE_STATIC;
         chanEnable_ff         <= 2'h0;
         strobeSrcTx_ff        <= 4'h0;
         strobeDedicated_ff    <= 4'h0;
         telecomControlMode_ff <= 1'b0;
      end else if (wrCtrl) begin
         ramDivisionMode_ff    <= hwdata[1:0];
         chanEnable_ff         <= hwdata[3:2];
         strobeSrcTx_ff        <= hwdata[11:8];
         strobeDedicated_ff    <= hwdata[15:12];
         telecomControlMode_ff <= hwdata[16];
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         shadowSwapRequest_ff <= 2'h0;
      end else begin
         shadowSwapRequest_ff <= (shadowSwapRequest_ff & ~swapDone)
                                 | ({2{wrCtrl}} & hwdata[5:4]);
      end
   end

   // Pin routing; swap comes from the receive entries only.
   logic swapA;
   logic rxBit;
   logic txBit;
   logic [5:0] txDest;
   logic [5:0] rxDest;
   logic txDrive;
   logic loopNow;
   assign swapA   = (slot[0].active & slot[0].swapTxRxPins)
                  | (slot[1].active & slot[1].swapTxRxPins);
   assign rxDest  = slot[0].destOneHot | slot[1].destOneHot;
   assign txDest  = slot[2].destOneHot | slot[3].destOneHot;
   assign loopNow = (slot[0].active & slot[0].loopSlot) | (slot[1].active & slot[1].loopSlot);
   assign rxBit   = loopNow ? txBit : (swapA ? pinSync[9] : pinSync[8]);
   assign txDrive = |txDest;
   always_comb begin
      txBit = 1'b0;
      for (int i = 0; i < NUM_DEST; i++) begin
         txBit = txBit | (txDest[i] & ctrlTxData[i]);
      end
   end

   logic [5:0] rxValid_ff;
   logic [5:0] rxData_ff;
   logic [5:0] txTake_ff;
   logic       txOut_ff;
   logic       txOe_ff;
   logic       txOnRx_ff;
   logic       grant_ff;
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         rxValid_ff <= '0;
         rxData_ff  <= '0;
         txTake_ff  <= '0;
         txOut_ff   <= 1'b0;
         txOe_ff    <= 1'b0;
         txOnRx_ff  <= 1'b0;
         grant_ff   <= 1'b0;
      end else begin
         rxValid_ff <= rxDest & {NUM_DEST{|edgeSel[1:0]}};
         rxData_ff  <= {NUM_DEST{rxBit}} & rxDest;
         txTake_ff  <= txDest & {NUM_DEST{|edgeSel[3:2]}};
         txOut_ff   <= txBit;
         txOe_ff    <= txDrive & ~loopNow;
         txOnRx_ff  <= swapA;
         grant_ff   <= telecomControlMode_ff & (slot[2].dChanGrant | slot[3].dChanGrant);
      end
   end
   assign ctrlRxValid     = rxValid_ff;
   assign ctrlRxData      = rxData_ff;
   assign ctrlTxTake      = txTake_ff;
   assign dChanGrant      = grant_ff;
   assign tdmTxDataPinOut = txOut_ff;
   assign tdmTxDataPinOe  = txOe_ff & ~txOnRx_ff;
   assign tdmRxDataPinOut = txOut_ff;
   assign tdmRxDataPinOe  = txOe_ff & txOnRx_ff;

   // Strobes: OR of all sets of the owning direction, idle slots give zero.
   logic [3:0] stbRx;
   logic [3:0] stbTx;
   logic [3:0] stb_ff;
   assign stbRx = slot[0].strobes | slot[1].strobes;
   assign stbTx = slot[2].strobes | slot[3].strobes;
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         stb_ff <= 4'h0;
      end else begin
         for (int i = 0; i < NUM_STROBES; i++) begin
            if (strobeSrcTx_ff[i] ? |edgeSel[3:2] : |edgeSel[1:0]) begin
               stb_ff[i] <= strobeSrcTx_ff[i] ? stbTx[i] : stbRx[i];
            end
         end
      end
   end
   assign {strobe_b2_pin, strobe_b1_pin, strobe_a2_pin, strobe_a1_pin} =
          stb_ff & strobeDedicated_ff;

   // Read data.
   always_comb begin
      hrdata = 32'h0;
      if (dpValid_ff && !dpWrite_ff) begin
         if (dpRam) begin
            hrdata = {16'h0, ram[dpAddr_ff[9:2]]};
         end else if (dpAddr_ff == OFS_CTRL) begin
            hrdata = {15'h0, telecomControlMode_ff, strobeDedicated_ff, strobeSrcTx_ff,
                      2'h0, shadowSwapRequest_ff, chanEnable_ff, ramDivisionMode_ff};
         end else if (dpAddr_ff == OFS_STAT) begin
            hrdata = {22'h0, rdAddr[0], shadowActive_ff};
         end
      end
   end
endmodule : tsr_slot_route
`default_nettype wire

// File: tb/tsr_route_monitor.sv
// Concurrent checks on the routing engine's bus, pin and strobe ports.
`timescale 1ns/1ps
`default_nettype none
module tsr_route_monitor (
   input wire logic        clk_sys,
   input wire logic        reset_n,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        tdmRxDataPinOe,
   input wire logic        tdmTxDataPinOe,
   input wire logic        strobe_a1_pin,
   input wire logic        strobe_b2_pin,
   input wire logic [5:0]  ctrlRxValid,
   input wire logic [5:0]  ctrlTxTake
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   a_bus_always_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   a_unmapped_read_zero: assert property (hsel && hready && htrans[1] && !hwrite
      && haddr >= 32'h408 && haddr < 32'h1000 |=> hrdata == 32'h0)
      else $error("unmapped read returned data");
   a_idle_rdata_zero: assert property (!(hsel && htrans[1]) |=> hrdata == 32'h0)
      else $error("read data outside a read data phase");
   a_one_pin_driven: assert property (!(tdmRxDataPinOe && tdmTxDataPinOe))
      else $error("both data pins driven at once");
   a_rx_unit_pulse: assert property (|ctrlRxValid |=> ctrlRxValid == 6'h0)
      else $error("receive unit pulse longer than one cycle");
   a_tx_unit_pulse: assert property (|ctrlTxTake |=> ctrlTxTake == 6'h0)
      else $error("transmit unit pulse longer than one cycle");
   a_strobe_a1_steady: assert property ($changed(strobe_a1_pin) |=> $stable(strobe_a1_pin))
      else $error("strobe a1 changed twice in a row");
   a_strobe_b2_steady: assert property ($changed(strobe_b2_pin) |=> $stable(strobe_b2_pin))
      else $error("strobe b2 changed twice in a row");
   a_reset_pins_quiet: assert property ($rose(reset_n) |-> !tdmRxDataPinOe
      && !tdmTxDataPinOe && ctrlRxValid == 6'h0 && !strobe_a1_pin)
      else $error("pins active straight after reset");
endmodule : tsr_route_monitor

bind tsr_slot_route tsr_route_monitor tsr_route_monitor_inst (
   .clk_sys        (clk_sys),
   .reset_n        (reset_n),
   .hsel           (hsel),
   .haddr          (haddr),
   .htrans         (htrans),
   .hwrite         (hwrite),
   .hready         (hready),
   .hrdata         (hrdata),
   .hreadyout      (hreadyout),
   .hresp          (hresp),
   .tdmRxDataPinOe (tdmRxDataPinOe),
   .tdmTxDataPinOe (tdmTxDataPinOe),
   .strobe_a1_pin  (strobe_a1_pin),
   .strobe_b2_pin  (strobe_b2_pin),
   .ctrlRxValid    (ctrlRxValid),
   .ctrlTxTake     (ctrlTxTake)
);
`default_nettype wire

// File: tb/tsr_far_end.sv
// Far-end TDM station model: shared link clock, frame sync and line levels.
`timescale 1ns/1ps
`default_nettype none
module tsr_far_end (
   output logic linkClk,
   output logic frameSync,
   output logic rxLine,
   output logic txLine
);
   logic rxLevel = 1'b0;
   logic txLevel = 1'b0;
   initial linkClk = 1'b0;
   initial frameSync = 1'b0;
   assign rxLine = rxLevel;
   assign txLine = txLevel;
   // The clock stands still low between frames; sync spans both edges of the first bit.
   task automatic frame(input int bits);
      frameSync = 1'b1;
      for (int i = 0; i < bits; i++) begin
         #50 frameSync = (i == 0);
         #50 linkClk = 1'b1;
         #100 linkClk = 1'b0;
      end
      #400;
   endtask : frame
endmodule : tsr_far_end
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench: route memory over the bus, frames from the far-end model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import tsr_pkg::*;
   logic        clk_sys = 1'b0;
   logic        reset_n = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [5:0]  ctrlTxData = 6'h0;
   logic [31:0] hrdata;
   logic [31:0] rdv;
   logic        hreadyout, hresp, rxOut, rxOe, txOut, txOe, a1, a2, b1, b2, grant;
   logic [5:0]  ctrlRxData, ctrlRxValid, ctrlTxTake;
   logic        rxOeSeen, grantSeen;
   wire         linkClk, frameSync, farRx, farTx;
   int          num_errors = 0;
   int          num_checks = 0;
   int          cnt[6], tcnt[6], ones[6], stbCnt;
   int          expCnt[6] = '{3, 8, 1, 16, 2, 1};
   logic [2:0]  chT[8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0, 3'h7};
   logic [3:0]  nT[8] = '{4'h2, 4'h0, 4'h0, 4'hf, 4'h1, 4'h0, 4'h1, 4'h0};

   always #12.5 clk_sys = ~clk_sys;

   tsr_slot_route tsr_slot_route_inst (
      .clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .rx_clock_chan_a(linkClk),
      .rx_clock_chan_b(linkClk), .tx_clock_chan_a(linkClk), .tx_clock_chan_b(linkClk),
      .rx_sync_chan_a(frameSync), .rx_sync_chan_b(frameSync), .tx_sync_chan_a(frameSync),
      .tx_sync_chan_b(frameSync), .tdmRxDataPinIn(rxOe ? rxOut : farRx),
      .tdmRxDataPinOut(rxOut),
      .tdmRxDataPinOe(rxOe), .tdmTxDataPinIn(txOe ? txOut : farTx), .tdmTxDataPinOut(txOut),
      .tdmTxDataPinOe(txOe), .strobe_a1_pin(a1), .strobe_a2_pin(a2), .strobe_b1_pin(b1),
      .strobe_b2_pin(b2), .ctrlTxData(ctrlTxData), .ctrlRxData(ctrlRxData),
      .ctrlRxValid(ctrlRxValid), .ctrlTxTake(ctrlTxTake), .dChanGrant(grant));

   tsr_far_end tsr_far_end_inst (.linkClk(linkClk), .frameSync(frameSync), .rxLine(farRx),
      .txLine(farTx));

   always @(posedge clk_sys) begin
      for (int i = 0; i < 6; i++) begin
         cnt[i] += (ctrlRxValid[i] === 1'b1);
         tcnt[i] += (ctrlTxTake[i] === 1'b1);
         ones[i] += (ctrlRxValid[i] === 1'b1 && ctrlRxData[i] === 1'b1);
      end
      rxOeSeen |= (rxOe === 1'b1);
      grantSeen |= (grant === 1'b1);
   end
   always @(posedge linkClk) stbCnt += ({a1, a2, b1, b2} === 4'hf);

   task automatic clr();
      cnt = '{default: 0};
      tcnt = '{default: 0};
      ones = '{default: 0};
      stbCnt = 0;
      rxOeSeen = 1'b0;
      grantSeen = 1'b0;
   endtask : clr

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic ahb(input logic wr, input logic [31:0] a, d, output logic [31:0] rd);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      rd = hrdata;
   endtask : ahb

   task automatic wr(input logic [31:0] a, d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask : wr

   task automatic rdc(input logic [31:0] a, exp);
      logic [31:0] x;
      ahb(1'b0, a, 32'h0, x);
      chk(x, exp);
   endtask : rdc

   function automatic logic [31:0] ent(logic lp, sw, logic [3:0] st, logic [2:0] ch,
                                       logic [3:0] n, logic by, ls);
      return {16'h0, lp, sw, st, 1'b0, ch, n, by, ls};
   endfunction : ent

   // One four-bit entry on channel code 001 in both directions, then a short frame.
   task automatic runOne(input logic lp, sw, input logic [31:0] ctl);
      wr(32'h0, ent(lp, sw, 4'h0, 3'h1, 4'h3, 1'b0, 1'b1));
      wr(32'h200, ent(1'b0, 1'b0, 4'h0, 3'h1, 4'h3, 1'b0, 1'b1));
      wr(32'h400, ctl);
      clr();
      tsr_far_end_inst.frame(10);
   endtask : runOne

   task automatic endTest(input string name);
      $display("test %s done: %0d checks, %0d errors", name, num_checks, num_errors);
   endtask : endTest

   task automatic print_verdict();
      $display("checks %0d, errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict

   initial begin
      #400000;
      num_errors++;
      $display("[FAIL] %0t ns: run did not finish in time", $time);
      print_verdict();
   end

   initial begin
      clr();
      repeat (12) @(posedge clk_sys);
      reset_n <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         wr(4 * i, ent(1'b0, 1'b0, (i < 2 || i == 7) ? 4'hf : 4'h0, chT[i], nT[i], i == 1, i == 7));
         wr(32'h200 + 4 * i, ent(1'b0, 1'b1, 4'h0, chT[i], nT[i], i == 1, i == 7));
      end
      rdc(32'hc, ent(1'b0, 1'b0, 4'h0, 3'h4, 4'hf, 1'b0, 1'b0));
      wr(32'h800, 32'h1234);
      rdc(32'h800, 32'h0);
      endTest("route_memory");
      tsr_far_end_inst.rxLevel = 1'b1;
      wr(32'h400, 32'h0000f004 | MODE_ONE_STATIC);
      clr();
      tsr_far_end_inst.frame(40);
      for (int i = 0; i < 6; i++) begin
         chk(cnt[i], expCnt[i]);
         chk(tcnt[i], expCnt[i]);
      end
      chk(ones[1], 8);
      chk(stbCnt, 12);
      chk(a1, 1'b0);
      chk(rxOeSeen, 1'b0);
      chk(grantSeen, 1'b0);
      wr(32'h400, 32'h00010004);
      clr();
      tsr_far_end_inst.frame(40);
      chk(cnt[3], 16);
      chk(stbCnt, 0);
      chk(grantSeen, 1'b1);
      endTest("routing_and_strobes");
      tsr_far_end_inst.rxLevel = 1'b0;
      tsr_far_end_inst.txLevel = 1'b1;
      runOne(1'b0, 1'b1, 32'h4);
      chk(cnt[0], 4);
      chk(ones[0], 4);
      chk(rxOeSeen, 1'b1);
      wr(32'h200, ent(1'b0, 1'b0, 4'h0, 3'h0, 4'h3, 1'b0, 1'b1));
      clr();
      tsr_far_end_inst.frame(10);
      chk(rxOeSeen, 1'b0);
      chk(ones[0], 4);
      endTest("pin_swap");
      tsr_far_end_inst.txLevel = 1'b0;
      @(posedge clk_sys);
      ctrlTxData <= 6'h01;
      runOne(1'b1, 1'b0, 32'h4);
      chk(ones[0], 4);
      endTest("loopback");
      runOne(1'b0, 1'b0, 32'h4 | MODE_TWO_DYNAMIC);
      chk(cnt[0], 4);
      wr(32'h80, ent(1'b0, 1'b0, 4'h0, 3'h2, 4'h3, 1'b0, 1'b1));
      wr(32'h280, ent(1'b0, 1'b0, 4'h0, 3'h2, 4'h3, 1'b0, 1'b1));
      wr(32'h400, 32'h17);
      rdc(32'h400, 32'h17);
      clr();
      tsr_far_end_inst.frame(10);
      chk(cnt[1], 4);
      chk(cnt[0], 0);
      rdc(32'h400, 32'h7);
      ahb(1'b0, 32'h404, 32'h0, rdv);
      chk(rdv & 32'h3, 32'h1);
      endTest("shadow_swap");
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
